/* pkg/ddc_pkg.sv */
package ddc_pkg;
	localparam int unsigned CLK_HZ   = 100_000_000;
	localparam int unsigned TICK_HZ  = 100_000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int unsigned GATE_US  = 10;
	localparam int unsigned GATE_CYC = GATE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned HF_HZ    = 200;
	localparam int unsigned HF_CYC   = CLK_HZ / HF_HZ;
	localparam logic [9:0]  TICK_LAST = 10'(TICK_DIV - 1);
	localparam logic [9:0]  GATE_LD   = 10'(GATE_CYC);
	localparam logic [7:0]  RET_VS    = 8'h80;
	localparam logic [3:0]  F_HIGH    = 4'h7;
	localparam logic [3:0]  F_FULL    = 4'h8;
	localparam logic [3:0]  F_LOWB    = 4'h2;
	localparam logic [3:0]  BIT_ACK   = 4'h8;
	localparam logic [3:0]  GUARD     = 4'hF;
	localparam logic [4:0]  PIN_IDLE  = 5'h1E;
	localparam logic [1:0]  Q_DRV     = 2'h0;
	localparam logic [1:0]  Q_REL     = 2'h1;
	localparam logic [1:0]  Q_SMP     = 2'h2;
	localparam logic [1:0]  Q_LAST    = 2'h3;
	localparam logic [9:0]  IDX_MST   = 10'h000;
	localparam logic [9:0]  IDX_BUF   = 10'h010;
	localparam logic [9:0]  IDX_FLG   = 10'h050;
	localparam logic [9:0]  IDX_EN    = 10'h060;
	localparam logic [9:0]  IDX_FIFO  = 10'h070;
	localparam logic [9:0]  IDX_WDT   = 10'h080;
	localparam logic [9:0]  IDX_SCTL  = 10'h090;
	localparam logic [9:0]  IDX_SST   = 10'h091;
	localparam logic [9:0]  IDX_SBUF  = 10'h092;
	localparam logic [9:0]  IDX_SADR  = 10'h093;
	localparam int MC_S = 0, MC_P = 1, MC_ACK = 2, MC_PROTECT_ABOVE_128 = 3, MC_PROTECT_ABOVE_256 = 4, MC_LD = 5, MC_LS = 6;
	localparam int IF_MI = 0, IF_FI = 1, WD_CLR = 5;
	localparam int SC_EN = 7, SC_SEL = 6, SC_EBI = 5, SC_EMI = 4;
	localparam int SS_WA = 7, SS_S = 6, SS_BI = 5, SS_MI = 4;
	localparam int MS_BUSY = 0;
	typedef struct packed {
		logic hclk;
		logic hdat;
		logic eclk;
		logic edat;
		logic vsync;
	} ddc_pins_t;
	typedef enum logic [1:0] {DDC_ID = 2'b01, DDC_BI = 2'b10} ddc_mode_t;
	typedef enum logic [4:0] {
		M_IDLE = 5'b00001, M_START = 5'b00010, M_XFER = 5'b00100, M_HOLD = 5'b01000, M_STOP = 5'b10000
	} ddc_mst_t;
endpackage

/* rtl/ddc_iic_interface.sv */
`timescale 1ns/1ps
// Contract
// RULE_01 - reset enters identification mode; vsync clocks data while host clock high
// RULE_02 - each FIFO byte goes out as eight data bits plus a 1 separator
// RULE_03 - FIFO-low status and interrupt when depth below select-chosen threshold
// RULE_04 - FIFO-high status when more than seven bytes wait
// RULE_05 - with auto-load set, reading master data pushes that byte into FIFO
// RULE_06 - host clock falling edge switches to bidirectional mode
// RULE_07 - bidirectional mode joins host pins to EEPROM pins
// RULE_08 - 128 vsync periods of high host clock returns, unless access seen
// RULE_09 - bidirectional flag shows mode; clear bit write clears it
// RULE_10 - protect bits block host EEPROM writes above 128 or 256
// RULE_11 - busy status reads 1 while host clock pin is low
// RULE_12 - software writes EEPROM: address, start, then byte or stop per interrupt
// RULE_13 - read: address bit0 1, ack bit, dummy read, stop before last read
// RULE_14 - idle start edge starts, stop edge stops; start 1 resumes; clock held low
// RULE_15 - start and stop bits sampled at 100KHz; pulses last 20us
// RULE_16 - master data access counts only 10us after master interrupt rises
// RULE_17 - FIFO flags follow fill level within 30us
// RULE_18 - clock error on held EEPROM clock, cleared by start 0; bus error per ack
// RULE_19 - high-frequency flag when vsync faster than 200Hz
// RULE_20 - events set flags; enabled flags pull interrupt low; write 0 clears
// RULE_21 - slave engine on pin pair per select, address match interrupt
// RULE_22 - slave drops address, marks word address, buffer interrupt, NACK if unread
module ddc_iic_interface #(
	parameter int unsigned HF_CYC = ddc_pkg::HF_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        host_clock_pin_in,
	output logic             host_clock_pin_out,
	output logic             host_clock_pin_oe,
	input  wire logic        host_data_pin_in,
	output logic             host_data_pin_out,
	output logic             host_data_pin_oe,
	input  wire logic        eeprom_clock_pin_in,
	output logic             eeprom_clock_pin_out,
	output logic             eeprom_clock_pin_oe,
	input  wire logic        eeprom_data_pin_in,
	output logic             eeprom_data_pin_out,
	output logic             eeprom_data_pin_oe,
	input  wire logic        vsync_in,
	output logic             cpu_ext_interrupt_n
);
	function automatic logic at(input logic [9:0] a, input logic [9:0] b);
		return a == b;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a level counts once stages two and three agree
	logic [4:0] s1_ff, s2_ff, s3_ff, flt_ff, pv_ff;
	ddc_pkg::ddc_pins_t pin_f, pin_p;
	always_ff @(posedge clock) begin
		s1_ff <= {host_clock_pin_in, host_data_pin_in, eeprom_clock_pin_in, eeprom_data_pin_in, vsync_in};
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		pv_ff <= rst ? ddc_pkg::PIN_IDLE : flt_ff;
	end
	for (genvar gi = 0; gi < 5; gi++) begin : g_flt
		always_ff @(posedge clock) begin
			if (rst)
				flt_ff[gi] <= ddc_pkg::PIN_IDLE[gi];
			else if (s2_ff[gi] == s3_ff[gi])
				flt_ff[gi] <= s3_ff[gi];
		end
	end
	assign pin_f = ddc_pkg::ddc_pins_t'(flt_ff);
	assign pin_p = ddc_pkg::ddc_pins_t'(pv_ff);
	wire hclk_fell = pin_p.hclk & ~pin_f.hclk;
	wire vs_rise   = ~pin_p.vsync & pin_f.vsync;

	// 100KHz sampling enable
	logic [9:0] tcnt_ff;
	logic       tick_ff;
	always_ff @(posedge clock) begin
		tcnt_ff <= (rst || tcnt_ff == ddc_pkg::TICK_LAST) ? '0 : tcnt_ff + 10'h001;
		tick_ff <= !rst && tcnt_ff == ddc_pkg::TICK_LAST;
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait, registered answer prepared in the setup cycle
	logic [31:0] prdata_ff;
	logic        pready_ff, pslverr_ff;
	logic [7:0]  mctl_ff, interrupt_enables_ff, sctl_ff, sadr_ff, rdv;
	wire  [9:0]  idx     = paddr[11:2];
	wire         setup   = psel & ~penable;
	wire         done    = psel & penable & pready_ff;
	wire         wr      = done & pwrite & pstrb[0];
	wire         rd      = done & ~pwrite;
	wire         mapped  = at(idx, ddc_pkg::IDX_MST) | at(idx, ddc_pkg::IDX_BUF) | at(idx, ddc_pkg::IDX_FLG)
	                     | at(idx, ddc_pkg::IDX_EN) | at(idx, ddc_pkg::IDX_FIFO) | at(idx, ddc_pkg::IDX_WDT)
	                     | at(idx, ddc_pkg::IDX_SCTL) | at(idx, ddc_pkg::IDX_SST) | at(idx, ddc_pkg::IDX_SBUF)
	                     | at(idx, ddc_pkg::IDX_SADR);
	wire  [7:0]  wd      = pwdata[7:0];
	always_ff @(posedge clock) begin
		pready_ff  <= !rst && setup;
		pslverr_ff <= !rst && setup && !mapped;
		if (rst)
			prdata_ff <= '0;
		else if (setup && !pwrite)
			prdata_ff <= {24'h000000, rdv};
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			mctl_ff  <= '0;
			interrupt_enables_ff <= '0;
			sctl_ff  <= '0;
			sadr_ff  <= '0;
		end else if (wr) begin
			if (at(idx, ddc_pkg::IDX_MST))  mctl_ff  <= wd;
			if (at(idx, ddc_pkg::IDX_EN))   interrupt_enables_ff <= wd;
			if (at(idx, ddc_pkg::IDX_SCTL)) sctl_ff  <= wd;
			if (at(idx, ddc_pkg::IDX_SADR)) sadr_ff  <= wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// identification FIFO
	logic [7:0] fmem [8];
	logic [2:0] wp_ff, rp_ff;
	logic [3:0] fcnt_ff;
	logic       fh_ff, fl_ff, fi_ff;
	logic [7:0] msh_ff;
	wire        master_data_register_rd = rd & at(idx, ddc_pkg::IDX_BUF);
	wire        fifo_wr = wr & at(idx, ddc_pkg::IDX_FIFO);
	wire        ld_rd   = master_data_register_rd & mctl_ff[ddc_pkg::MC_LD]; // RULE_05
	wire        push    = (fifo_wr | ld_rd) & (fcnt_ff != ddc_pkg::F_FULL);
	wire [7:0]  pdat    = fifo_wr ? pwdata[7:0] : msh_ff;
	wire [3:0]  thr     = {2'b00, mctl_ff[ddc_pkg::MC_LS +: 2]} + ddc_pkg::F_LOWB;
	logic       pop;
	always_ff @(posedge clock) begin
		if (push)
			fmem[wp_ff] <= pdat;
		if (rst) begin
			wp_ff   <= '0;
			rp_ff   <= '0;
			fcnt_ff <= '0;
		end else begin
			wp_ff   <= wp_ff + 3'(push);
			rp_ff   <= rp_ff + 3'(pop);
			fcnt_ff <= fcnt_ff + 4'(push) - 4'(pop);
		end
	end
	// flags refresh every 10us, well inside the 30us promise
	always_ff @(posedge clock) begin
		if (rst) begin
			fh_ff <= 1'b0;
			fl_ff <= 1'b1;
		end else if (tick_ff) begin
			fh_ff <= fcnt_ff > ddc_pkg::F_HIGH; // RULE_04 RULE_17
			fl_ff <= fcnt_ff < thr; // RULE_03 RULE_17
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode control and identification stream
	ddc_pkg::ddc_mode_t mode_ff;
	logic       lock_ff, id_oe_ff;
	logic [7:0] vcnt_ff;
	logic [8:0] tx_ff;
	logic [3:0] bc_ff;
	wire        ddc_clr = wr & at(idx, ddc_pkg::IDX_WDT) & pwdata[ddc_pkg::WD_CLR];
	wire        is_id   = mode_ff == ddc_pkg::DDC_ID;
	wire        vs_step = is_id & vs_rise & pin_f.hclk; // RULE_01
	assign pop = vs_step && bc_ff == ddc_pkg::BIT_ACK && fcnt_ff != '0;
	always_ff @(posedge clock) begin
		if (rst)
			mode_ff <= ddc_pkg::DDC_ID; // RULE_01
		else if (hclk_fell)
			mode_ff <= ddc_pkg::DDC_BI; // RULE_06
		else if (ddc_clr || (!lock_ff && vcnt_ff == ddc_pkg::RET_VS))
			mode_ff <= ddc_pkg::DDC_ID; // RULE_08 RULE_09
		vcnt_ff <= (rst || is_id || !pin_f.hclk) ? '0 : vcnt_ff + 8'(vs_rise);
	end
	always_ff @(posedge clock) begin
		if (rst || !is_id) begin
			tx_ff <= '1;
			bc_ff <= ddc_pkg::BIT_ACK;
		end else if (vs_step) begin
			if (bc_ff == ddc_pkg::BIT_ACK) begin
				tx_ff <= {(fcnt_ff != '0) ? fmem[rp_ff] : 8'hFF, 1'b1}; // RULE_02
				bc_ff <= '0;
			end else begin
				tx_ff <= {tx_ff[7:0], 1'b1};
				bc_ff <= bc_ff + 4'h1;
			end
		end
		id_oe_ff <= !rst && is_id && !tx_ff[8];
	end

	////////////////////////////////////////////////////////////////////////////
	// host bus watcher: access lock and write protection
	logic [3:0] hbit_ff;
	logic [1:0] hbyt_ff;
	logic [7:0] hsh_ff;
	logic       hwr_ff, ha8_ff, blk_ff;
	wire        is_bi  = mode_ff == ddc_pkg::DDC_BI;
	wire        hstart = is_bi & pin_p.hdat & ~pin_f.hdat & pin_f.hclk;
	wire        hstop  = is_bi & ~pin_p.hdat & pin_f.hdat & pin_f.hclk;
	wire        hrise  = is_bi & ~pin_p.hclk & pin_f.hclk;
	always_ff @(posedge clock) begin
		if (rst || ddc_clr) begin
			lock_ff <= 1'b0;
			hbit_ff <= '0;
			hbyt_ff <= '0;
			blk_ff  <= 1'b0;
		end else if (hstart || hstop) begin
			hbit_ff <= '0;
			hbyt_ff <= '0;
			blk_ff  <= 1'b0;
		end else if (hrise) begin
			if (hbit_ff == ddc_pkg::BIT_ACK) begin
				hbit_ff <= '0;
				hbyt_ff <= hbyt_ff + 2'(hbyt_ff != 2'h3);
				if (hbyt_ff == 2'h0) begin
					lock_ff <= lock_ff | ~pin_f.hdat; // RULE_08
					hwr_ff  <= ~hsh_ff[0];
					ha8_ff  <= hsh_ff[1];
				end else if (hbyt_ff == 2'h1)
					blk_ff <= hwr_ff & ((mctl_ff[ddc_pkg::MC_PROTECT_ABOVE_128] & (hsh_ff[7] | ha8_ff))
					        | (mctl_ff[ddc_pkg::MC_PROTECT_ABOVE_256] & ha8_ff)); // RULE_10
			end else begin
				hsh_ff  <= {hsh_ff[6:0], pin_f.hdat};
				hbit_ff <= hbit_ff + 4'h1;
			end
		end
	end

	// pass-through; the guard keeps an echo of our own drive from turning the direction round
	logic       byp_clk_ff, h2e_ff, e2h_ff, m_sda_ff;
	logic [3:0] gd_ff;
	always_ff @(posedge clock) begin
		byp_clk_ff <= !rst && is_bi && !pin_f.hclk && !blk_ff; // RULE_07 RULE_10
		h2e_ff <= !rst && is_bi && !pin_f.hdat && !e2h_ff && (h2e_ff || gd_ff == '0); // RULE_07
		e2h_ff <= !rst && is_bi && !pin_f.edat && !h2e_ff && !m_sda_ff && (e2h_ff || gd_ff == '0);
		gd_ff  <= rst ? '0 : (h2e_ff || e2h_ff) ? ddc_pkg::GUARD : gd_ff - 4'(gd_ff != '0);
	end

	////////////////////////////////////////////////////////////////////////////
	// master engine on the EEPROM pins, paced by the 100KHz enable
	ddc_pkg::ddc_mst_t mst_ff;
	logic [1:0] mq_ff;
	logic [3:0] mbit_ff;
	logic       m_scl_ff, mrd_ff, mfirst_ff, mi_ff, bus_error_flag_ff, clock_error_flag_ff, s_smp_ff, p_smp_ff;
	logic [9:0] gate_ff;
	wire        s_rise = tick_ff & mctl_ff[ddc_pkg::MC_S] & ~s_smp_ff; // RULE_15
	wire        p_rise = tick_ff & mctl_ff[ddc_pkg::MC_P] & ~p_smp_ff; // RULE_15
	wire        macc   = done & at(idx, ddc_pkg::IDX_BUF) & (gate_ff == '0); // RULE_16
	wire        m_wr   = macc & pwrite & pstrb[0];
	wire        m_step = tick_ff & (mst_ff != ddc_pkg::M_IDLE) & (mst_ff != ddc_pkg::M_HOLD);
	wire        m_done = m_step && mst_ff == ddc_pkg::M_XFER && mq_ff == ddc_pkg::Q_LAST
	                     && mbit_ff == ddc_pkg::BIT_ACK;
	always_ff @(posedge clock) begin
		if (rst) begin
			s_smp_ff <= 1'b0;
			p_smp_ff <= 1'b0;
		end else if (tick_ff) begin
			s_smp_ff <= mctl_ff[ddc_pkg::MC_S];
			p_smp_ff <= mctl_ff[ddc_pkg::MC_P];
		end
		mq_ff <= (rst || (tick_ff && !m_step)) ? ddc_pkg::Q_DRV : mq_ff + 2'(m_step);
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			mst_ff    <= ddc_pkg::M_IDLE;
			m_scl_ff  <= 1'b0;
			m_sda_ff  <= 1'b0;
			mbit_ff   <= '0;
			mrd_ff    <= 1'b0;
			mfirst_ff <= 1'b0;
			msh_ff    <= '0;
			bus_error_flag_ff   <= 1'b0;
		end else begin
			if (m_wr && mst_ff != ddc_pkg::M_XFER)
				msh_ff <= pwdata[7:0];
			unique case (mst_ff)
				ddc_pkg::M_IDLE: begin
					m_scl_ff <= 1'b0;
					m_sda_ff <= 1'b0;
					if (p_rise)
						mst_ff <= ddc_pkg::M_STOP; // RULE_14
					else if (s_rise && !mctl_ff[ddc_pkg::MC_P]) begin
						mst_ff    <= ddc_pkg::M_START; // RULE_14
						mfirst_ff <= 1'b1; // RULE_12
						mrd_ff    <= 1'b0;
					end
				end
				ddc_pkg::M_START: if (m_step) begin
					if (mq_ff == ddc_pkg::Q_REL) m_sda_ff <= 1'b1;
					if (mq_ff == ddc_pkg::Q_SMP) m_scl_ff <= 1'b1;
					if (mq_ff == ddc_pkg::Q_LAST) begin
						mst_ff  <= ddc_pkg::M_XFER;
						mbit_ff <= '0;
					end
				end
				ddc_pkg::M_XFER: if (m_step) begin
					unique case (mq_ff)
						ddc_pkg::Q_DRV: m_sda_ff <= (mbit_ff == ddc_pkg::BIT_ACK) ? (mrd_ff & ~mctl_ff[ddc_pkg::MC_ACK])
						                                                 : (~mrd_ff & ~msh_ff[7]); // RULE_13
						ddc_pkg::Q_REL: m_scl_ff <= 1'b0;
						ddc_pkg::Q_SMP: begin
							if (mbit_ff != ddc_pkg::BIT_ACK)
								msh_ff <= {msh_ff[6:0], pin_f.edat};
							else begin
								if (!mrd_ff) bus_error_flag_ff <= pin_f.edat; // RULE_18
								if (mfirst_ff) mrd_ff <= msh_ff[0]; // RULE_13
								mfirst_ff <= 1'b0;
							end
						end
						ddc_pkg::Q_LAST: begin
							m_scl_ff <= 1'b1;
							mbit_ff  <= mbit_ff + 4'h1;
							if (m_done) begin
								mst_ff   <= ddc_pkg::M_HOLD;
								m_sda_ff <= 1'b0;
							end
						end
					endcase
				end
				ddc_pkg::M_HOLD: begin
					mbit_ff <= '0;
					if (p_rise || (macc && mctl_ff[ddc_pkg::MC_P]))
						mst_ff <= ddc_pkg::M_STOP; // RULE_13 RULE_14
					else if (macc && mctl_ff[ddc_pkg::MC_S])
						mst_ff <= ddc_pkg::M_XFER; // RULE_12 RULE_14
				end
				ddc_pkg::M_STOP: if (m_step) begin
					if (mq_ff == ddc_pkg::Q_DRV) m_sda_ff <= 1'b1;
					if (mq_ff == ddc_pkg::Q_REL) m_scl_ff <= 1'b0;
					if (mq_ff == ddc_pkg::Q_SMP) m_sda_ff <= 1'b0;
					if (mq_ff == ddc_pkg::Q_LAST) mst_ff <= ddc_pkg::M_IDLE;
				end
			endcase
		end
	end
	// sticky flags: a set in the same cycle as a clear wins
	wire flg_wr = wr & at(idx, ddc_pkg::IDX_FLG);
	always_ff @(posedge clock) begin
		if (rst) begin
			mi_ff     <= 1'b0;
			fi_ff     <= 1'b0;
			clock_error_flag_ff <= 1'b0;
			gate_ff   <= '0;
		end else begin
			mi_ff <= m_done | (mi_ff & ~(flg_wr & ~pwdata[ddc_pkg::IF_MI])); // RULE_13 RULE_20
			fi_ff <= fl_ff | (fi_ff & ~(flg_wr & ~pwdata[ddc_pkg::IF_FI])); // RULE_03 RULE_20
			clock_error_flag_ff <= (m_step && mst_ff == ddc_pkg::M_XFER && mq_ff == ddc_pkg::Q_SMP && !pin_f.eclk)
			           | (clock_error_flag_ff & mctl_ff[ddc_pkg::MC_S]); // RULE_18
			gate_ff <= m_done ? ddc_pkg::GATE_LD : gate_ff - 10'(gate_ff != '0); // RULE_16
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// vsync rate check; the period limit is a parameter so a bench can shorten it
	logic [19:0] vper_ff;
	logic        hf_ff;
	always_ff @(posedge clock) begin
		if (rst) begin
			vper_ff <= '0;
			hf_ff   <= 1'b0;
		end else if (vs_rise) begin
			vper_ff <= '0;
			hf_ff   <= vper_ff < 20'(HF_CYC); // RULE_19
		end else
			vper_ff <= vper_ff + 20'(vper_ff != '1);
	end

	////////////////////////////////////////////////////////////////////////////
	// receive-only slave engine
	logic [3:0] sbit_ff;
	logic [7:0] ssh_ff, sbuf_ff;
	logic       sst_ff, sadrp_ff, sact_ff, sdrv_ff, sbi_ff, smi_ff, swa_ff, sfirst_ff;
	wire        ssel   = sctl_ff[ddc_pkg::SC_SEL]; // RULE_21
	wire        sc_f   = ssel ? pin_f.eclk : pin_f.hclk;
	wire        sc_p   = ssel ? pin_p.eclk : pin_p.hclk;
	wire        sd_f   = ssel ? pin_f.edat : pin_f.hdat;
	wire        sd_p   = ssel ? pin_p.edat : pin_p.hdat;
	wire        sstart = sc_f & sd_p & ~sd_f;
	wire        sstop  = sc_f & ~sd_p & sd_f;
	wire        s_ack  = ~sc_f & sc_p && sbit_ff == ddc_pkg::BIT_ACK;
	wire        s_take = s_ack & ~sadrp_ff & sact_ff & ~sbi_ff;
	always_ff @(posedge clock) begin
		if (rst || !sctl_ff[ddc_pkg::SC_EN] || sstop) begin
			sst_ff  <= 1'b0;
			sact_ff <= 1'b0;
			sdrv_ff <= 1'b0;
			sbit_ff <= '0;
		end else if (sstart) begin
			sst_ff   <= 1'b1;
			sadrp_ff <= 1'b1;
			sact_ff  <= 1'b0;
			sbit_ff  <= '0;
		end else if (sc_f && !sc_p) begin
			sbit_ff <= (sbit_ff == ddc_pkg::BIT_ACK) ? '0 : sbit_ff + 4'h1;
			if (sbit_ff != ddc_pkg::BIT_ACK)
				ssh_ff <= {ssh_ff[6:0], sd_f};
		end else if (s_ack) begin
			if (sadrp_ff) begin
				sact_ff   <= ssh_ff[7:1] == sadr_ff[7:1] && !ssh_ff[0]; // RULE_21
				sdrv_ff   <= ssh_ff[7:1] == sadr_ff[7:1] && !ssh_ff[0];
				sadrp_ff  <= 1'b0;
				sfirst_ff <= 1'b1; // RULE_22
			end else begin
				sdrv_ff <= s_take; // RULE_22
				if (s_take)
					sfirst_ff <= 1'b0;
			end
		end else if (~sc_f && sc_p && sbit_ff == '0)
			sdrv_ff <= 1'b0;
	end
	wire s_match = s_ack & sadrp_ff & (ssh_ff[7:1] == sadr_ff[7:1]) & ~ssh_ff[0];
	always_ff @(posedge clock) begin
		if (rst) begin
			sbi_ff <= 1'b0;
			smi_ff <= 1'b0;
			swa_ff <= 1'b0;
			sbuf_ff <= '0;
		end else begin
			if (s_take) begin
				sbuf_ff <= ssh_ff;
				swa_ff  <= sfirst_ff; // RULE_22
			end
			sbi_ff <= s_take | (sbi_ff & ~(rd & at(idx, ddc_pkg::IDX_SBUF))); // RULE_22
			smi_ff <= s_match | (smi_ff & ~(wr & at(idx, ddc_pkg::IDX_SST) & ~pwdata[ddc_pkg::SS_MI])); // RULE_21
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux and pin drivers
	always_comb begin
		rdv = 8'h00;
		if (at(idx, ddc_pkg::IDX_MST))
			rdv = {1'b0, clock_error_flag_ff, is_bi, bus_error_flag_ff, hf_ff, fh_ff, fl_ff, ~pin_f.hclk}; // RULE_09 RULE_11
		if (at(idx, ddc_pkg::IDX_BUF))  rdv = msh_ff;
		if (at(idx, ddc_pkg::IDX_FLG))  rdv = {6'h00, fi_ff, mi_ff};
		if (at(idx, ddc_pkg::IDX_SST))  rdv = {swa_ff, sst_ff, sbi_ff, smi_ff, 4'h0};
		if (at(idx, ddc_pkg::IDX_SBUF)) rdv = sbuf_ff;
	end
	logic hd_oe_ff, ec_oe_ff, ed_oe_ff, irq_n_ff, low_ff;
	always_ff @(posedge clock) begin
		low_ff   <= 1'b0;
		hd_oe_ff <= !rst && (id_oe_ff || e2h_ff || (sdrv_ff && !ssel)); // RULE_02 RULE_07
		ec_oe_ff <= !rst && (m_scl_ff || byp_clk_ff); // RULE_14
		ed_oe_ff <= !rst && (m_sda_ff || h2e_ff || (sdrv_ff && ssel));
		irq_n_ff <= rst || !((mi_ff && interrupt_enables_ff[ddc_pkg::IF_MI]) || (fi_ff && interrupt_enables_ff[ddc_pkg::IF_FI])
		            || (sbi_ff && sctl_ff[ddc_pkg::SC_EBI]) || (smi_ff && sctl_ff[ddc_pkg::SC_EMI])); // RULE_20
	end
	assign prdata               = prdata_ff;
	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign host_clock_pin_out   = low_ff;
	assign host_clock_pin_oe    = low_ff;
	assign host_data_pin_out    = low_ff;
	assign host_data_pin_oe     = hd_oe_ff;
	assign eeprom_clock_pin_out = low_ff;
	assign eeprom_clock_pin_oe  = ec_oe_ff;
	assign eeprom_data_pin_out  = low_ff;
	assign eeprom_data_pin_oe   = ed_oe_ff;
	assign cpu_ext_interrupt_n  = irq_n_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence sep_due;
		vs_step && bc_ff == 4'h7;
	endsequence
	reset_mode_a: assert property ($fell(rst) |-> is_id) // RULE_01
		else $error("not in identification mode after reset");
	sep_bit_a: assert property (sep_due |=> tx_ff[8] ##1 !id_oe_ff) // RULE_02
		else $error("separator bit not released");
	fifo_low_a: assert property (tick_ff |=> fl_ff == ($past(fcnt_ff) < $past(thr))) // RULE_03
		else $error("fifo low status wrong");
	fifo_high_a: assert property (tick_ff |=> fh_ff == ($past(fcnt_ff) == 4'h8)) // RULE_04
		else $error("fifo high status wrong");
	auto_load_a: assert property (ld_rd && !fifo_wr && !pop && fcnt_ff < 4'h8 |=> fcnt_ff == $past(fcnt_ff) + 4'h1) // RULE_05
		else $error("auto load did not push");
	scl_fall_a: assert property (hclk_fell |=> is_bi) // RULE_06
		else $error("no switch on host clock fall");
	ret_ident_a: assert property (is_bi && !lock_ff && vcnt_ff == 8'h80 && !hclk_fell |=> is_id) // RULE_08
		else $error("no return after 128 vsync periods");
	busy_read_a: assert property (setup && !pwrite && at(idx, 10'h000) |=> prdata_ff[0] == !$past(pin_f.hclk)) // RULE_11
		else $error("busy status wrong");
	master_data_register_gate_a: assert property ($rose(mi_ff) |-> (gate_ff != '0) [*8]) // RULE_16
		else $error("master data access not gated");
	irq_pin_a: assert property (mi_ff && interrupt_enables_ff[0] |=> !irq_n_ff) // RULE_20
		else $error("interrupt output not low");
endmodule

/* tb/ddc_far_end.sv */
`timescale 1ns/1ps
module ddc_far_end (
	input  wire logic host_pull_low,
	input  wire logic hclk_oe,
	input  wire logic hdat_oe,
	input  wire logic eclk_oe,
	input  wire logic edat_oe,
	output logic      hclk,
	output logic      hdat,
	output logic      eclk,
	output logic      edat
);
	// pull-ups on all lines: a released line reads high
	assign hclk = ~(host_pull_low | hclk_oe);
	assign hdat = ~hdat_oe;
	assign eclk = ~eclk_oe;
	assign edat = ~edat_oe;
endmodule

/* tb/ddc_iic_interface_tb.sv */
`timescale 1ns/1ps
module ddc_iic_interface_tb;
	logic        clock, rst, psel, penable, pwrite, vsync, hlow, err, irq_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, hco, hce, hdo, hde, eco, ece, edo, ede, hc, hd, ec, ed;
	logic [7:0]  q[$];
	logic [7:0]  mv;
	int          errors, samples_checked, d;
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	ddc_far_end far (.host_pull_low(hlow), .hclk_oe(hce), .hdat_oe(hde), .eclk_oe(ece), .edat_oe(ede),
		.hclk(hc), .hdat(hd), .eclk(ec), .edat(ed));
	ddc_iic_interface #(.HF_CYC(2000)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_clock_pin_in(hc), .host_clock_pin_out(hco), .host_clock_pin_oe(hce),
		.host_data_pin_in(hd), .host_data_pin_out(hdo), .host_data_pin_oe(hde), .eeprom_clock_pin_in(ec),
		.eeprom_clock_pin_out(eco), .eeprom_clock_pin_oe(ece), .eeprom_data_pin_in(ed),
		.eeprom_data_pin_out(edo), .eeprom_data_pin_oe(ede), .vsync_in(vsync), .cpu_ext_interrupt_n(irq_n));
	task automatic end_of_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// one transfer; an idle edge follows so back-to-back calls never reassign in one step
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] v);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, v};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			$display("wrong value at %0t: no pready", $time);
			errors++;
			end_of_test();
		end else
			@(posedge clock);
	endtask
	function automatic logic [7:0] fifo_exp(input int depth, input int ls);
		return {5'h00, depth > 7, depth < ls + 2, 1'b0};
	endfunction
	// one 9-bit packet; vsync stands still outside it
	task automatic pkt(input logic [7:0] v);
		logic [8:0] e;
		e = {v, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			vsync <= 1'b1;
			repeat (4) @(posedge clock);
			vsync <= 1'b0;
			repeat (4) @(posedge clock);
			chk({7'h00, hd}, {7'h00, e[i]});
		end
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, vsync, hlow, errors, samples_checked} = '0;
		rst = 1'b1;
		void'($urandom(997));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(0, ddc_pkg::IDX_MST, 8'h00);
		chk(rd[7:0] & 8'h21, 8'h00);
		apb(0, 10'h020, 8'h00);
		chk({7'h00, err}, 8'h01);
		apb(0, ddc_pkg::IDX_FLG, 8'h00);
		chk(rd[7:0] & 8'h02, 8'h02);
		apb(1, ddc_pkg::IDX_EN, 8'h02);
		repeat (5) @(posedge clock);
		chk({7'h00, irq_n}, 8'h00);
		$display("reset and irq test done");
		for (d = 0; d <= 8; d++) begin
			apb(1, ddc_pkg::IDX_MST, 8'((d % 4) << 6));
			repeat (3000) @(posedge clock);
			apb(0, ddc_pkg::IDX_MST, 8'h00);
			chk(rd[7:0] & 8'h06, fifo_exp(d, d % 4));
			q.push_back(8'($urandom));
			apb(1, ddc_pkg::IDX_FIFO, q[$]);
		end
		apb(1, ddc_pkg::IDX_FLG, 8'h00);
		repeat (5) @(posedge clock);
		chk({7'h00, irq_n}, 8'h01);
		$display("fifo level test done");
		pkt(q[0]);
		pkt(q[1]);
		apb(0, ddc_pkg::IDX_MST, 8'h00);
		chk(rd[7:0] & 8'h08, 8'h08);
		$display("stream test done");
		hlow <= 1'b1;
		repeat (12) @(posedge clock);
		chk({7'h00, ec}, 8'h00);
		apb(0, ddc_pkg::IDX_MST, 8'h00);
		chk(rd[7:0] & 8'h21, 8'h21);
		hlow <= 1'b0;
		repeat (12) @(posedge clock);
		apb(1, ddc_pkg::IDX_WDT, 8'h20);
		apb(0, ddc_pkg::IDX_MST, 8'h00);
		chk(rd[7:0] & 8'h21, 8'h00);
		$display("mode test done");
		apb(1, ddc_pkg::IDX_EN, 8'h01);
		mv = 8'($urandom) & 8'hFE;
		apb(1, ddc_pkg::IDX_BUF, mv);
		apb(1, ddc_pkg::IDX_MST, 8'h01);
		for (d = 0; d < 45000 && irq_n !== 1'b0; d++)
			@(posedge clock);
		chk({7'h00, irq_n}, 8'h00);
		chk({7'h00, ec}, 8'h00);
		apb(1, ddc_pkg::IDX_BUF, ~mv);
		apb(0, ddc_pkg::IDX_BUF, 8'h00);
		chk(rd[7:0], mv);
		apb(0, ddc_pkg::IDX_MST, 8'h00);
		chk(rd[7:0] & 8'h50, 8'h10);
		apb(1, ddc_pkg::IDX_MST, 8'h02);
		repeat (6000) @(posedge clock);
		chk({6'h00, ec, ed}, 8'h03);
		$display("master test done");
		apb(1, ddc_pkg::IDX_MST, 8'h22);
		apb(0, ddc_pkg::IDX_BUF, 8'h00);
		apb(0, ddc_pkg::IDX_BUF, 8'h00);
		repeat (3000) @(posedge clock);
		apb(0, ddc_pkg::IDX_MST, 8'h00);
		chk(rd[7:0] & 8'h04, 8'h04);
		$display("auto load test done");
		end_of_test();
	end
endmodule
